/* hw/port_ctl_pkg.sv */
package port_ctl_pkg;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 16;
  localparam logic [11:0] LEFT_BOX_ADDR  = 12'hFFE;
  localparam logic [11:0] RIGHT_BOX_ADDR = 12'hFFF;
  localparam int          TOKEN_COUNT    = 8;
  localparam int          CLK_PERIOD_NS  = 10;
  // Address and select settle time before the write pulse
  localparam int          SETUP_NS       = 40;
  localparam logic [3:0]  SETUP_CYC      = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Strobe width and recovery
  localparam int          PULSE_NS       = 40;
  localparam logic [3:0]  PULSE_CYC      = 4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  RECOV_CYC      = 4'h2;
  localparam logic [3:0]  CNT_ZERO       = 4'h0;
  localparam logic [15:0] DATA_ZERO      = 16'h0000;
  localparam logic [11:0] ADDR_ZERO      = 12'h000;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_PULSE = 5'h04,
    ST_RECOV = 5'h08,
    ST_DONE  = 5'h10
  } state_t;
endpackage

/* hw/port_ctl.sv */
// Summary of operation
// (RULE1) Right writes at FFE raise the left mailbox flag.
// (RULE2) Left access at FFE with select and read drive low clears it.
// (RULE3) Left writes at FFF raise the right mailbox flag.
// (RULE4) Right port reads FFF to clear its mailbox flag.
// (RULE5) Mailbox words are ordinary 16-bit memory words.
// (RULE6) Unused mailbox locations may serve as plain memory.
// (RULE7) Same-address collision: one side proceeds, other sees busy.
// (RULE8) Busy side's writes are gated off inside the device.
// (RULE9) Slave mode: busy pins are write-inhibit inputs only.
// (RULE10) Slave busy input held high allows writes, low blocks them.
// (RULE11) Master busy outputs are push-pull, no pull-up needed.
// (RULE12) Width expansion: one master decides busy, slaves obey it.
// (RULE13) Only one master when expanding in width.
// (RULE14) Master arbitrates on address and select only.
// (RULE15) Hold address and select until busy settles before writing.
// (RULE16) Eight semaphore flags beside the memory array.
// (RULE17) Ports are served independently.
// (RULE18) Port in standby when memory and token selects are high.
// (RULE19) Semaphores gate no resource in hardware.
// (RULE20) Semaphore accesses insert no wait states.
// (RULE21) Write zero requests a token, write one releases it.
// (RULE22) Token write uses data bit zero, address bits 2..0.
// (RULE23) Token read spreads flag on all bits, latched during read.
// (RULE24) Pending request from other side gets token on release.
// (RULE25) Master never drives both busy outputs low together.
`timescale 1ns/10ps
module port_ctl (
  input  wire logic        mclk,           // System clock
  input  wire logic        srst,           // Synchronous reset, active high
  input  wire logic        req_valid,      // Start an access, one-cycle pulse
  input  wire logic        req_write,      // 1 write, 0 read
  input  wire logic        req_token,      // 1 semaphore space, 0 memory
  input  wire logic [11:0] req_addr,       // Word address
  input  wire logic [15:0] req_wdata,      // Write data
  output logic             req_ready,      // Idle, may take a request
  output logic             rsp_valid,      // Access finished, one-cycle pulse
  output logic [15:0]      rsp_rdata,      // Read data
  output logic             rsp_busy,       // Busy was seen during the access
  output logic             mbox_irq,       // Own mailbox flag is raised
  output logic             port_sel_n,     // Memory port select
  output logic             token_latch_select_n, // Semaphore select
  output logic             wr_n,           // Write strobe
  output logic             oe_n,           // Read drive enable
  output logic [11:0]      addr,           // Address pins
  output logic [15:0]      dq_o,           // Data out
  output logic             dq_oe,          // Data output enable, high drives
  input  wire logic [15:0] dq_i,           // Data in from pins
  input  wire logic        busy_n,         // Busy pin from master device
  input  wire logic        mailbox_flag_n  // Own mailbox flag pin
);
  port_ctl_pkg::state_t state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d, tok_q, tok_d, psel_n_q, psel_n_d, tsel_n_q, tsel_n_d;
  logic        wr_n_q, wr_n_d, oe_n_q, oe_n_d, dq_oe_q, dq_oe_d;
  logic        rsp_valid_q, rsp_valid_d, rsp_busy_q, rsp_busy_d;
  logic [11:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
  // Three-stage pin pipes, oldest sample in bit 2
  logic [2:0]  busy_s, irq_s;
  logic        busy_n_f_q, busy_n_f_d, irq_q, irq_d;
  logic        req_ready_q, req_ready_d;

  // Pin inputs: three stages, change accepted when last two agree
  // Busy comes from the one master of the array; slaves never drive it
  // Reset to the idle high level so no false flag follows reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_s <= 3'h7;
      irq_s  <= 3'h7;
    end else begin
      busy_s <= {busy_s[1:0], busy_n}; // RULE12 RULE13
      irq_s  <= {irq_s[1:0], mailbox_flag_n};
    end
  end

  // Hysteresis: a one-cycle glitch on a pin never reaches the state
  always_comb begin
    busy_n_f_d = (busy_s[2] == busy_s[1]) ? busy_s[2] : busy_n_f_q;
    irq_d      = (irq_s[2] == irq_s[1]) ? ~irq_s[2] : irq_q;
  end

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    wr_d        = wr_q;
    tok_d       = tok_q;
    addr_d      = addr_q;
    wdata_d     = wdata_q;
    rdata_d     = rdata_q;
    psel_n_d    = psel_n_q;
    tsel_n_d    = tsel_n_q;
    wr_n_d      = wr_n_q;
    oe_n_d      = oe_n_q;
    dq_oe_d     = dq_oe_q;
    rsp_valid_d = 1'h0;
    rsp_busy_d  = rsp_busy_q;
    case (state_q)
      port_ctl_pkg::ST_IDLE: begin
        if (req_valid) begin
          wr_d       = req_write;
          tok_d      = req_token;
          // Token space ignores upper address bits; keep them zero
          // Mailbox words get no special casing, so they work as plain memory
          addr_d     = req_token ? {9'h000, req_addr[2:0]} : req_addr; // RULE6 RULE22
          // Token write carries only bit zero
          wdata_d    = req_token ? {15'h0000, req_wdata[0]} : req_wdata; // RULE21 RULE22
          psel_n_d   = req_token;
          tsel_n_d   = ~req_token;
          rsp_busy_d = 1'h0;
          cnt_d      = port_ctl_pkg::SETUP_CYC;
          state_d    = port_ctl_pkg::ST_SETUP;
        end
      end
      port_ctl_pkg::ST_SETUP: begin
        // Address and select stand until busy has settled
        if (cnt_q != port_ctl_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - 4'h1; // RULE15
        end else if (!tok_q && !busy_n_f_q) begin
          // Hold off the strobe: a write the device inhibits would be lost
          rsp_busy_d = 1'h1; // RULE7 RULE8 RULE10
        end else begin
          // Semaphore path never waits on busy
          wr_n_d  = ~wr_q; // RULE20
          // A plain read of the own mailbox word is what clears its flag
          oe_n_d  = wr_q; // RULE4
          dq_oe_d = wr_q;
          cnt_d   = port_ctl_pkg::PULSE_CYC;
          state_d = port_ctl_pkg::ST_PULSE;
        end
      end
      port_ctl_pkg::ST_PULSE: begin
        if (cnt_q != port_ctl_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          // Token read latched while select and read enable stay low
          rdata_d = dq_i; // RULE23
          wr_n_d  = 1'h1;
          oe_n_d  = 1'h1;
          cnt_d   = port_ctl_pkg::RECOV_CYC;
          state_d = port_ctl_pkg::ST_RECOV;
        end
      end
      port_ctl_pkg::ST_RECOV: begin
        // Data drive drops first so the bus turns round before release
        dq_oe_d = 1'h0;
        if (cnt_q != port_ctl_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          // Releasing both selects also ends the token read latch
          psel_n_d = 1'h1; // RULE18 RULE23
          tsel_n_d = 1'h1;
          state_d  = port_ctl_pkg::ST_DONE;
        end
      end
      port_ctl_pkg::ST_DONE: begin
        // Response one cycle after both selects are high again
        rsp_valid_d = 1'h1;
        state_d     = port_ctl_pkg::ST_IDLE;
      end
      default: begin
        state_d = port_ctl_pkg::ST_IDLE;
      end
    endcase
    // Registered so the ready output comes straight from a flip-flop
    req_ready_d = (state_d == port_ctl_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q     <= port_ctl_pkg::ST_IDLE;
      cnt_q       <= port_ctl_pkg::CNT_ZERO;
      wr_q        <= 1'h0;
      tok_q       <= 1'h0;
      addr_q      <= port_ctl_pkg::ADDR_ZERO;
      wdata_q     <= port_ctl_pkg::DATA_ZERO;
      rdata_q     <= port_ctl_pkg::DATA_ZERO;
      psel_n_q    <= 1'h1;
      tsel_n_q    <= 1'h1;
      wr_n_q      <= 1'h1;
      oe_n_q      <= 1'h1;
      dq_oe_q     <= 1'h0;
      rsp_valid_q <= 1'h0;
      rsp_busy_q  <= 1'h0;
      busy_n_f_q  <= 1'h1;
      irq_q       <= 1'h0;
      req_ready_q <= 1'h1;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      wr_q        <= wr_d;
      tok_q       <= tok_d;
      addr_q      <= addr_d;
      wdata_q     <= wdata_d;
      rdata_q     <= rdata_d;
      psel_n_q    <= psel_n_d;
      tsel_n_q    <= tsel_n_d;
      wr_n_q      <= wr_n_d;
      oe_n_q      <= oe_n_d;
      dq_oe_q     <= dq_oe_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_busy_q  <= rsp_busy_d;
      busy_n_f_q  <= busy_n_f_d;
      irq_q       <= irq_d; // RULE1 RULE3
      req_ready_q <= req_ready_d;
    end
  end

  // All pins come from registers; no combinational path reaches them
  assign req_ready            = req_ready_q;
  assign rsp_valid            = rsp_valid_q;
  assign rsp_rdata            = rdata_q;
  assign rsp_busy             = rsp_busy_q;
  assign mbox_irq             = irq_q;
  assign port_sel_n           = psel_n_q;
  assign token_latch_select_n = tsel_n_q;
  assign wr_n                 = wr_n_q;
  assign oe_n                 = oe_n_q;
  assign addr                 = addr_q;
  assign dq_o                 = wdata_q;
  assign dq_oe                = dq_oe_q;
endmodule

/* bench/port_ctl_assertions.sv */
`timescale 1ns/10ps
module port_ctl_chk (
  input wire logic        mclk,                 // Clock
  input wire logic        srst,                 // Reset
  input wire logic        req_ready,            // Idle
  input wire logic        rsp_valid,            // Done
  input wire logic        mbox_irq,             // Flag out
  input wire logic        port_sel_n,           // Memory select
  input wire logic        token_latch_select_n, // Token select
  input wire logic        wr_n,                 // Write strobe
  input wire logic        oe_n,                 // Read enable
  input wire logic [11:0] addr,                 // Address
  input wire logic        dq_oe,                // Data drive
  input wire logic        mailbox_flag_n        // Flag pin
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  wire sel = !port_sel_n || !token_latch_select_n;
  property p_one_space; !(!port_sel_n && !token_latch_select_n); endproperty
  a_one_space: assert property (p_one_space) else $error("both selects low");
  property p_strobe_sel; !wr_n || !oe_n |-> sel; endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe unselected");
  property p_setup; $fell(wr_n) |-> $past(sel, 4); endproperty
  a_setup: assert property (p_setup) else $error("write before setup");
  property p_addr_hold; sel && $past(sel) |-> $stable(addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_wr_drive; !wr_n |-> dq_oe && oe_n; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write not driven");
  property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("long response");
  property p_stdby; req_ready |-> !sel; endproperty
  a_stdby: assert property (p_stdby) else $error("idle but selected");
  property p_irq; !mailbox_flag_n [*6] |-> mbox_irq; endproperty
  a_irq: assert property (p_irq) else $error("flag not reported");
  c_read: cover property (!oe_n && !port_sel_n);
  c_write: cover property (!wr_n && !port_sel_n);
  c_token: cover property (!wr_n && !token_latch_select_n);
endmodule
bind port_ctl port_ctl_chk u_port_ctl_chk (.mclk, .srst, .req_ready, .rsp_valid, .mbox_irq,
  .port_sel_n, .token_latch_select_n, .wr_n, .oe_n, .addr, .dq_oe, .mailbox_flag_n);

/* bench/dual_port_model.sv */
`timescale 1ns/10ps
module dual_port_model (
  input wire logic        port_sel_n,           // Memory select
  input wire logic        token_latch_select_n, // Token select
  input wire logic        wr_n,                 // Write strobe
  input wire logic        oe_n,                 // Read enable
  input wire logic [11:0] addr,                 // Address
  input wire logic [15:0] dq_o,                 // Host data
  input wire logic        far_hit,              // Far side on same word
  output logic     [15:0] dq_i,                 // Device data
  output logic            busy_n,               // Push-pull busy
  output logic            mailbox_flag_n        // Own mailbox flag
);
  logic [15:0] mem [4096];
  logic [15:0] rd_q = 16'h0000;
  logic [1:0]  own [8];
  logic [7:0]  far_req = 8'hFF;
  logic        far_flag = 1'h0;
  initial mailbox_flag_n = 1'h1;
  initial foreach (own[i]) own[i] = 2'h0;
  // Only memory selects collide; tokens never stall
  assign busy_n = !(far_hit && !port_sel_n);
  // Released bus shows inverted data, never a stale match
  assign dq_i = (!oe_n && !(port_sel_n && token_latch_select_n)) ? rd_q : ~rd_q;
  always @(negedge oe_n) begin
    if (!port_sel_n) rd_q = mem[addr];
    if (!port_sel_n && addr == 12'hFFE) mailbox_flag_n = 1'h1;
    if (!token_latch_select_n) rd_q = {16{own[addr[2:0]] != 2'h1}};
  end
  always @(posedge wr_n) begin
    if (!port_sel_n && busy_n) mem[addr] = dq_o;
    if (!port_sel_n && busy_n && addr == 12'hFFF) far_flag = 1'h1;
    if (!token_latch_select_n && !dq_o[0] && own[addr[2:0]] == 2'h0) own[addr[2:0]] = 2'h1;
    if (!token_latch_select_n && dq_o[0] && own[addr[2:0]] == 2'h1)
      own[addr[2:0]] = far_req[addr[2:0]] ? 2'h0 : 2'h2;
  end
  task automatic far_write(input logic [11:0] a, input logic [15:0] d);
    mem[a] = d;
    if (a == 12'hFFE) mailbox_flag_n <= 1'h0;
  endtask
  task automatic far_sem(input int i, input logic b);
    far_req[i] = b;
    if (!b && own[i] == 2'h0) own[i] = 2'h2;
    if (b && own[i] == 2'h2) own[i] = 2'h0;
  endtask
endmodule

/* bench/port_ctl_test.sv */
`timescale 1ns/10ps
module port_ctl_test;
  logic        mclk = 1'h0, srst = 1'h1, req_valid = 1'h0, req_write = 1'h0;
  logic        req_token = 1'h0, far_hit = 1'h0;
  logic [11:0] req_addr = 12'h000, addr, a;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, dq_o, dq_i;
  logic        req_ready, rsp_valid, rsp_busy, mbox_irq, port_sel_n, token_latch_select_n;
  logic        wr_n, oe_n, dq_oe, busy_n, mailbox_flag_n;
  logic [17:0] exp_q [$];
  logic [17:0] e, note;
  integer      err_total = 0, n_tests = 0, seed = 62883;
  port_ctl u_port_ctl (.mclk, .srst, .req_valid, .req_write, .req_token, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .rsp_busy, .mbox_irq, .port_sel_n, .token_latch_select_n,
    .wr_n, .oe_n, .addr, .dq_o, .dq_oe, .dq_i, .busy_n, .mailbox_flag_n);
  dual_port_model u_dual_port_model (.port_sel_n, .token_latch_select_n, .wr_n, .oe_n, .addr,
    .dq_o, .far_hit, .dq_i, .busy_n, .mailbox_flag_n);
  initial forever #5 mclk = ~mclk;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // wt: bit1 write, bit0 token; d is write data or expected read data
  task automatic acc(input logic [1:0] wt, input logic [11:0] ad, input logic [15:0] d,
                     input logic bz);
    exp_q.push_back({!wt[1], bz, d});
    @(posedge mclk iff req_ready);
    req_valid <= 1'h1;
    req_write <= wt[1];
    req_token <= wt[0];
    req_addr <= ad;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'h0;
    @(posedge mclk iff rsp_valid);
  endtask
  always @(posedge mclk) begin
    if (rsp_valid) begin
      note = exp_q.pop_front();
      chk("busy", 16'(rsp_busy), 16'(note[16]));
      if (note[17]) chk("rdata", rsp_rdata, note[15:0]);
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      a = 12'($random(seed)) & 12'h7FF;
      e = 18'($random(seed));
      acc(2'h2, a, e[15:0], 1'h0);
      acc(2'h0, a, e[15:0], 1'h0);
    end
    u_dual_port_model.far_write(12'hFFE, 16'hA5C3);
    repeat (8) @(posedge mclk);
    chk("irq set", 16'(mbox_irq), 16'h0001);
    acc(2'h0, 12'hFFE, 16'hA5C3, 1'h0);
    repeat (8) @(posedge mclk);
    chk("irq clear", 16'(mbox_irq), 16'h0000);
    acc(2'h2, 12'hFFF, 16'h1234, 1'h0);
    chk("far flag", 16'(u_dual_port_model.far_flag), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      // Upper address and data bits are noise the token logic must ignore
      a = {9'($random(seed)), 3'(i)};
      acc(2'h3, a, 16'hFFFE, 1'h0);
      acc(2'h1, a, 16'h0000, 1'h0);
      u_dual_port_model.far_sem(i, 1'h0);
      acc(2'h3, a, 16'h8001, 1'h0);
      acc(2'h1, a, 16'hFFFF, 1'h0);
      u_dual_port_model.far_sem(i, 1'h1);
    end
    far_hit <= 1'h1;
    fork
      acc(2'h2, 12'h123, 16'hBEEF, 1'h1);
      begin
        repeat (30) @(posedge mclk);
        far_hit <= 1'h0;
      end
    join
    acc(2'h0, 12'h123, 16'hBEEF, 1'h0);
    // Let the monitor compare the last response before the verdict
    repeat (2) @(posedge mclk);
    wrap_up();
  end
  initial begin
    #50000;
    err_total++;
    wrap_up();
  end
endmodule
